// *** src/cpp_top.sv ***
// cpp_top: cache policy control and prefetch-queue store snoop
// assumes fetch/store ports synchronous to clk; register port reads one cycle late
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module cpp_top #(
	parameter int DEPTH = cpp_pkg::PQ_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata_q,
	input wire cpp_pkg::cpp_access_t acc,
	input wire logic store_valid,
	input wire logic [cpp_pkg::ADDR_W-1:0] store_lin_addr,
	input wire logic [cpp_pkg::ADDR_W-1:0] store_next_ip,
	input wire logic fetch_push,
	input wire logic [cpp_pkg::ADDR_W-1:0] fetch_lin_addr,
	input wire logic retire_pop,
	input wire logic serialize,
	input wire logic ext_cache_off,
	input wire logic ext_write_through,
	output cpp_pkg::cpp_decision_t dec_q,
	output logic pq_flush_q,
	output logic [cpp_pkg::ADDR_W-1:0] refetch_addr_q,
	output logic pq_full_q
);
	localparam int PW = $clog2(DEPTH);

	// pointer wrap relies on a power-of-two depth
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
		$error("cpp_top: DEPTH must be a power of two, at least 2");
	end

	logic [31:0] ctrl_q;
	logic [31:0] ptb_q;
	logic [31:0] rbase_q [cpp_pkg::NUM_RANGES];
	logic [31:0] rmask_q [cpp_pkg::NUM_RANGES];
	logic [31:0] flush_cnt_q;
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [PW:0] count_q;

	// register decode
	wire wr_ctrl = reg_wr && reg_addr == cpp_pkg::REG_CTRL;
	wire wr_ptb = reg_wr && reg_addr == cpp_pkg::REG_PTB;
	wire wr_rb0 = reg_wr && reg_addr == cpp_pkg::REG_R0_BASE;
	wire wr_rm0 = reg_wr && reg_addr == cpp_pkg::REG_R0_MASK;
	wire wr_rb1 = reg_wr && reg_addr == cpp_pkg::REG_R1_BASE;
	wire wr_rm1 = reg_wr && reg_addr == cpp_pkg::REG_R1_MASK;

	wire global_cache_off_flag = ctrl_q[cpp_pkg::CTL_CACHE_OFF_BIT];
	wire global_no_write_through_flag = ctrl_q[cpp_pkg::CTL_NO_WT_BIT];
	wire range_en = ctrl_q[cpp_pkg::CTL_RANGE_EN_BIT];
	wire [1:0] page_bits = {ptb_q[cpp_pkg::PTB_CACHE_OFF_BIT],
		ptb_q[cpp_pkg::PTB_WRITE_THROUGH_BIT]};

	// memory range match; lower index wins when two overlap
	logic [cpp_pkg::NUM_RANGES-1:0] rhit;
	genvar gr;
	generate
		for (gr = 0; gr < cpp_pkg::NUM_RANGES; gr++) begin : g_rng
			assign rhit[gr] = rmask_q[gr][cpp_pkg::RM_VALID_BIT]
				&& ((acc.lin_addr[31:cpp_pkg::RANGE_ALIGN]
				& rmask_q[gr][31:cpp_pkg::RANGE_ALIGN])
				== (rbase_q[gr][31:cpp_pkg::RANGE_ALIGN]
				& rmask_q[gr][31:cpp_pkg::RANGE_ALIGN]));
		end
	endgenerate
	wire range_hit = |rhit;
	wire [2:0] range_type = rhit[0] ? rbase_q[0][2:0] : rbase_q[1][2:0];

	// one decision drives L1D, L2 and L1I
	cpp_policy u_policy (
		.clk(clk),
		.rst_n(rst_n),
		.global_cache_off_flag(global_cache_off_flag),
		.global_no_write_through_flag(global_no_write_through_flag),
		.range_en(range_en),
		.range_hit(range_hit),
		.range_type(range_type),
		.ext_cache_off(ext_cache_off),
		.ext_write_through(ext_write_through),
		.page_bits(page_bits),
		.acc(acc),
		.dec_q(dec_q)
	);

	// prefetch queue slots
	logic [DEPTH-1:0] slot_valid;
	logic [DEPTH-1:0] slot_hit;
	logic [DEPTH-1:0] slot_load;
	logic [DEPTH-1:0] slot_clear;
	wire do_push = fetch_push && !count_q[PW];
	wire do_pop = retire_pop && count_q != '0;
	wire snoop_hit = store_valid && |slot_hit;
	wire flush_now = snoop_hit || serialize;

	genvar gs;
	generate
		for (gs = 0; gs < DEPTH; gs++) begin : g_pq
			assign slot_load[gs] = do_push && wr_ptr_q == PW'(gs);
			assign slot_clear[gs] = flush_now || (do_pop && rd_ptr_q == PW'(gs));
			cpp_pq_entry #(.AW(cpp_pkg::ADDR_W)) u_ent (
				.clk(clk),
				.rst_n(rst_n),
				.load(slot_load[gs]),
				.clear(slot_clear[gs]),
				.load_addr(fetch_lin_addr),
				.cmp_addr(store_lin_addr),
				.valid_q(slot_valid[gs]),
				.hit(slot_hit[gs])
			);
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else if (flush_now) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_q + PW'(do_push);
			rd_ptr_q <= rd_ptr_q + PW'(do_pop);
			count_q <= count_q + (PW+1)'(do_push) - (PW+1)'(do_pop);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pq_flush_q <= 1'b0;
			refetch_addr_q <= '0;
			pq_full_q <= 1'b0;
			flush_cnt_q <= '0;
		end else begin
			pq_flush_q <= flush_now;
			if (flush_now)
				refetch_addr_q <= store_next_ip;
			if (flush_now)
				flush_cnt_q <= flush_cnt_q + 32'h0000_0001;
			pq_full_q <= !flush_now && (count_q + (PW+1)'(do_push) - (PW+1)'(do_pop))
				== (PW+1)'(DEPTH);
		end
	end

	// register writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= cpp_pkg::CTRL_RESET;
			ptb_q <= '0;
			rbase_q[0] <= '0;
			rbase_q[1] <= '0;
			rmask_q[0] <= '0;
			rmask_q[1] <= '0;
		end else begin
			if (wr_ctrl)
				ctrl_q <= {29'h0, reg_wdata[2:0]};
			if (wr_ptb)
				ptb_q <= reg_wdata;
			if (wr_rb0)
				rbase_q[0] <= reg_wdata;
			if (wr_rm0)
				rmask_q[0] <= reg_wdata;
			if (wr_rb1)
				rbase_q[1] <= reg_wdata;
			if (wr_rm1)
				rmask_q[1] <= reg_wdata;
		end
	end

	// read mux; unmapped reads zero
	logic [31:0] rd_mux;
	wire [31:0] status_w = {{(31-PW-8){1'b0}}, count_q, slot_valid[0],
		1'b0, dec_q.l1i_cacheable, dec_q.l2_policy, dec_q.l1d_policy[1:0]};
	always_comb begin
		case (reg_addr)
			cpp_pkg::REG_CTRL: rd_mux = ctrl_q;
			cpp_pkg::REG_PTB: rd_mux = ptb_q;
			cpp_pkg::REG_R0_BASE: rd_mux = rbase_q[0];
			cpp_pkg::REG_R0_MASK: rd_mux = rmask_q[0];
			cpp_pkg::REG_R1_BASE: rd_mux = rbase_q[1];
			cpp_pkg::REG_R1_MASK: rd_mux = rmask_q[1];
			cpp_pkg::REG_STATUS: rd_mux = status_w;
			cpp_pkg::REG_FLUSHES: rd_mux = flush_cnt_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata_q <= '0;
		else
			reg_rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
	end
endmodule // cpp_top
`default_nettype wire

// *** include/cpp_pkg.sv ***
// cache policy / prefetch snoop package: shared types and constants
// assumes a single 25 MHz core clock and synchronous inputs
package cpp_pkg;
	localparam int ADDR_W = 32;
	localparam int PQ_DEPTH = 8;
	localparam int LINE_SHIFT = 0;
	// control-flag encoding {cache_off, no_write_through}
	localparam logic [1:0] CTL_WRITEBACK = 2'h0;
	// memory range types
	localparam logic [2:0] MRT_UC = 3'h0;
	localparam logic [2:0] MRT_WC = 3'h1;
	localparam logic [2:0] MRT_WT = 3'h4;
	localparam logic [2:0] MRT_WP = 3'h5;
	localparam logic [2:0] MRT_WB = 3'h6;
	localparam int NUM_RANGES = 2;
	// register indices (word address = index)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_PTB = 4'h1;
	localparam logic [3:0] REG_R0_BASE = 4'h2;
	localparam logic [3:0] REG_R0_MASK = 4'h3;
	localparam logic [3:0] REG_R1_BASE = 4'h4;
	localparam logic [3:0] REG_R1_MASK = 4'h5;
	localparam logic [3:0] REG_STATUS = 4'h6;
	localparam logic [3:0] REG_FLUSHES = 4'h7;
	// field positions
	localparam int CTL_CACHE_OFF_BIT = 0;
	localparam int CTL_NO_WT_BIT = 1;
	localparam int CTL_RANGE_EN_BIT = 2;
	localparam int PTB_WRITE_THROUGH_BIT = 3;
	localparam int PTB_CACHE_OFF_BIT = 4;
	localparam int RB_TYPE_LSB = 0;
	localparam int RM_VALID_BIT = 11;
	localparam int RANGE_ALIGN = 12;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0003;

	typedef enum logic [2:0] {
		CPP_POL_UNCACHED = 3'h1,
		CPP_POL_WTHROUGH = 3'h2,
		CPP_POL_WBACK = 3'h4
	} cpp_policy_t;

	typedef struct packed {
		logic valid;
		logic is_store;
		logic [ADDR_W-1:0] lin_addr;
		logic page_cache_off_attr;
		logic page_write_through_attr;
		logic pde_cache_off;
		logic pde_write_through;
	} cpp_access_t;

	typedef struct packed {
		logic valid;
		cpp_policy_t l1d_policy;
		cpp_policy_t l2_policy;
		logic l1i_cacheable;
	} cpp_decision_t;
endpackage

// *** src/cpp_pq_entry.sv ***
// cpp_pq_entry: one prefetch-queue slot holding a linear address
// assumes clear and load never matter in the same slot beyond clear priority
`timescale 1ns/10ps
`default_nettype none
module cpp_pq_entry #(
	parameter int AW = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic clear,
	input wire logic [AW-1:0] load_addr,
	input wire logic [AW-1:0] cmp_addr,
	output logic valid_q,
	output logic hit
);
	logic [AW-1:0] addr_q;

	assign hit = valid_q && (addr_q == cmp_addr);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_q <= 1'b0;
			addr_q <= '0;
		end else if (clear) begin
			valid_q <= 1'b0;
		end else if (load) begin
			valid_q <= 1'b1;
			addr_q <= load_addr;
		end
	end
endmodule // cpp_pq_entry
`default_nettype wire

// *** src/cpp_policy.sv ***
// cpp_policy: combines global flags, range types, page bits, external force
// assumes all inputs steady and synchronous; result registered one cycle later
`timescale 1ns/10ps
`default_nettype none
module cpp_policy (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic global_cache_off_flag,
	input wire logic global_no_write_through_flag,
	input wire logic range_en,
	input wire logic range_hit,
	input wire logic [2:0] range_type,
	input wire logic ext_cache_off,
	input wire logic ext_write_through,
	input wire logic [1:0] page_bits,
	input wire cpp_pkg::cpp_access_t acc,
	output cpp_pkg::cpp_decision_t dec_q
);
	logic use_range;
	logic base_off;
	logic base_wt;
	logic eff_off;
	logic eff_wt;
	cpp_pkg::cpp_policy_t pol;

	assign use_range = range_en && range_hit;
	assign base_off = use_range ? (range_type == cpp_pkg::MRT_UC || range_type == cpp_pkg::MRT_WC)
		: global_cache_off_flag;
	assign base_wt = use_range ? (range_type == cpp_pkg::MRT_WT || range_type == cpp_pkg::MRT_WP)
		: ({global_cache_off_flag, global_no_write_through_flag} != cpp_pkg::CTL_WRITEBACK);
	// page bits from base reg, directory, table
	assign eff_off = base_off || page_bits[1] || acc.pde_cache_off || acc.page_cache_off_attr
		|| ext_cache_off;
	assign eff_wt = base_wt || page_bits[0] || acc.pde_write_through
		|| acc.page_write_through_attr || ext_write_through;
	assign pol = eff_off ? cpp_pkg::CPP_POL_UNCACHED
		: (eff_wt ? cpp_pkg::CPP_POL_WTHROUGH : cpp_pkg::CPP_POL_WBACK);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_q <= '{valid: 1'b0, l1d_policy: cpp_pkg::CPP_POL_UNCACHED,
				l2_policy: cpp_pkg::CPP_POL_UNCACHED, l1i_cacheable: 1'b0};
		end else begin
			dec_q <= '{valid: acc.valid, l1d_policy: pol, l2_policy: pol,
				l1i_cacheable: !eff_off};
		end
	end
endmodule // cpp_policy
`default_nettype wire

// *** dv/cpp_top_props.sv ***
// checker: port timing of cpp_top policy and snoop outputs
// assumes one clk domain, bound onto cpp_top
`timescale 1ns/10ps
`default_nettype none
module cpp_top_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire cpp_pkg::cpp_access_t acc,
	input wire logic store_valid,
	input wire logic [cpp_pkg::ADDR_W-1:0] store_next_ip,
	input wire logic serialize,
	input wire logic ext_cache_off,
	input wire logic ext_write_through,
	input wire cpp_pkg::cpp_decision_t dec_q,
	input wire logic pq_flush_q,
	input wire logic [cpp_pkg::ADDR_W-1:0] refetch_addr_q,
	input wire logic pq_full_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_unc;
		##1 dec_q.l1d_policy == cpp_pkg::CPP_POL_UNCACHED;
	endsequence
	sequence s_flush;
		##1 pq_flush_q;
	endsequence
	property p_valid; acc.valid |=> dec_q.valid; endproperty
	a_valid: assert property (p_valid) else $error("decision valid missing");
	property p_ext_off; ext_cache_off |-> s_unc; endproperty
	a_ext_off: assert property (p_ext_off) else $error("ext cache off ignored");
	property p_ext_wt; ext_write_through |=> dec_q.l2_policy != cpp_pkg::CPP_POL_WBACK; endproperty
	a_ext_wt: assert property (p_ext_wt) else $error("ext write-through ignored");
	property p_pte_off; acc.page_cache_off_attr |-> s_unc; endproperty
	a_pte_off: assert property (p_pte_off) else $error("page cache off ignored");
	property p_pde_off; acc.pde_cache_off |-> s_unc; endproperty
	a_pde_off: assert property (p_pde_off) else $error("dir cache off ignored");
	property p_pwt;
		acc.page_write_through_attr || acc.pde_write_through
			|=> dec_q.l1d_policy != cpp_pkg::CPP_POL_WBACK;
	endproperty
	a_pwt: assert property (p_pwt) else $error("page write-through ignored");
	property p_hot; dec_q.valid |-> $onehot(dec_q.l2_policy); endproperty
	a_hot: assert property (p_hot) else $error("policy not one-hot");
	property p_ser; serialize |-> s_flush; endproperty
	a_ser: assert property (p_ser) else $error("serialize did not flush");
	property p_cause; pq_flush_q |-> $past(store_valid) || $past(serialize); endproperty
	a_cause: assert property (p_cause) else $error("flush without cause");
	property p_refetch;
		$past(store_valid) && !$past(serialize) && pq_flush_q
			|-> refetch_addr_q == $past(store_next_ip);
	endproperty
	a_refetch: assert property (p_refetch) else $error("wrong refetch address");
	property p_empty; pq_flush_q |-> !pq_full_q; endproperty
	a_empty: assert property (p_empty) else $error("queue full after flush");
endmodule // cpp_top_props
bind cpp_top cpp_top_props u_props (.clk(clk), .rst_n(rst_n), .acc(acc),
	.store_valid(store_valid), .store_next_ip(store_next_ip), .serialize(serialize),
	.ext_cache_off(ext_cache_off), .ext_write_through(ext_write_through), .dec_q(dec_q),
	.pq_flush_q(pq_flush_q), .refetch_addr_q(refetch_addr_q), .pq_full_q(pq_full_q));
`default_nettype wire

// *** dv/cpp_core_model.sv ***
// partner: core fetch and store units facing the snoop port
// assumes tasks are called by the bench, one at a time
`timescale 1ns/10ps
`default_nettype none
module cpp_core_model (
	input wire logic clk,
	output logic fetch_push,
	output logic [31:0] fetch_lin_addr,
	output logic retire_pop,
	output logic store_valid,
	output logic [31:0] store_lin_addr,
	output logic [31:0] store_next_ip,
	output logic serialize
);
	initial begin
		{fetch_push, retire_pop, store_valid, serialize} = 4'h0;
		{fetch_lin_addr, store_lin_addr, store_next_ip} = '0;
	end
	// idle address lines show the inverse, never a stale match
	task automatic push(input logic [31:0] a);
		@(posedge clk);
		fetch_push <= 1'b1;
		fetch_lin_addr <= a;
		@(posedge clk);
		fetch_push <= 1'b0;
		fetch_lin_addr <= ~a;
	endtask
	task automatic pop();
		@(posedge clk);
		retire_pop <= 1'b1;
		@(posedge clk);
		retire_pop <= 1'b0;
	endtask
	task automatic store(input logic [31:0] a, input logic [31:0] nip);
		@(posedge clk);
		store_valid <= 1'b1;
		store_lin_addr <= a;
		store_next_ip <= nip;
		@(posedge clk);
		store_valid <= 1'b0;
		store_lin_addr <= ~a;
		store_next_ip <= ~nip;
	endtask
	task automatic ser();
		@(posedge clk);
		serialize <= 1'b1;
		@(posedge clk);
		serialize <= 1'b0;
	endtask
endmodule // cpp_core_model
`default_nettype wire

// *** dv/cpp_top_tb.sv ***
// testbench: registers, cache policy and prefetch snoop of cpp_top
// assumes cpp_core_model drives the fetch and store side
`timescale 1ns/10ps
`default_nettype none
module cpp_top_tb;
	localparam logic [2:0] P_UN = cpp_pkg::CPP_POL_UNCACHED;
	localparam logic [2:0] P_WT = cpp_pkg::CPP_POL_WTHROUGH;
	localparam logic [2:0] P_WB = cpp_pkg::CPP_POL_WBACK;
	logic clk, rst_n, reg_wr, reg_rd, ext_cache_off, ext_write_through;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata_q, refetch_addr_q, fa, sa, sn;
	logic fp, rp, sv, sz, pq_flush_q, pq_full_q;
	cpp_pkg::cpp_access_t acc;
	cpp_pkg::cpp_decision_t dec_q;
	logic [2:0] rt [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
	logic [2:0] re [5] = '{P_UN, P_UN, P_WT, P_WT, P_WB};
	logic [3:0] pg [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
	int err_count = 0;
	int n_tests = 0;
	int i;
	cpp_top #(.DEPTH(8)) DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.acc(acc), .store_valid(sv), .store_lin_addr(sa), .store_next_ip(sn),
		.fetch_push(fp), .fetch_lin_addr(fa), .retire_pop(rp), .serialize(sz),
		.ext_cache_off(ext_cache_off), .ext_write_through(ext_write_through), .dec_q(dec_q),
		.pq_flush_q(pq_flush_q), .refetch_addr_q(refetch_addr_q), .pq_full_q(pq_full_q));
	cpp_core_model u_core (.clk(clk), .fetch_push(fp), .fetch_lin_addr(fa), .retire_pop(rp),
		.store_valid(sv), .store_lin_addr(sa), .store_next_ip(sn), .serialize(sz));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("rdata", exp, reg_rdata_q);
	endtask
	// exp of zero means any policy except writeback
	task automatic pol(input logic [31:0] a, input logic [3:0] p, input logic [2:0] exp);
		@(posedge clk);
		acc <= '{1'b1, 1'b0, a, p[3], p[2], p[1], p[0]};
		@(posedge clk);
		#1;
		if (exp === 3'h0) begin
			chk("l1d_not_wb", 32'h1, {31'h0, dec_q.l1d_policy !== P_WB});
		end else begin
			chk("l1d", {29'h0, exp}, {29'h0, dec_q.l1d_policy});
			chk("l2", {29'h0, exp}, {29'h0, dec_q.l2_policy});
			chk("l1i", {31'h0, exp != P_UN}, {31'h0, dec_q.l1i_cacheable});
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		$display("watchdog expired");
		stop_test();
	end
	initial begin
		{rst_n, reg_wr, reg_rd, ext_cache_off, ext_write_through} = 5'h0;
		{reg_addr, reg_wdata, acc} = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(cpp_pkg::REG_CTRL, cpp_pkg::CTRL_RESET);
		wr(4'h8, 32'h0000_00ff);
		rd(4'h8, 32'h0);
		for (i = 0; i < 4; i++) begin
			wr(cpp_pkg::REG_CTRL, i);
			pol(32'h0003_0000, 4'h0, (i == 0) ? P_WB : 3'h0);
		end
		$display("test global flags done");
		wr(cpp_pkg::REG_CTRL, 32'h0000_0007);
		wr(cpp_pkg::REG_R0_MASK, 32'hffff_f800);
		for (i = 0; i < 5; i++) begin
			wr(cpp_pkg::REG_R0_BASE, {16'h0001, 13'h0, rt[i]});
			pol(32'h0001_0234, 4'h0, re[i]);
		end
		pol(32'h0002_0000, 4'h0, 3'h0);
		rd(cpp_pkg::REG_R0_MASK, 32'hffff_f800);
		wr(cpp_pkg::REG_R1_BASE, 32'h0003_0005);
		rd(cpp_pkg::REG_R1_BASE, 32'h0003_0005);
		$display("test ranges done");
		pol(32'h0001_0234, 4'h4, P_WT);
		wr(cpp_pkg::REG_CTRL, 32'h0000_0004);
		for (i = 0; i < 4; i++) begin
			pol(32'h0003_0000, pg[i], (i % 2 == 0) ? P_UN : P_WT);
		end
		wr(cpp_pkg::REG_PTB, 32'h0000_0010);
		pol(32'h0003_0000, 4'h0, P_UN);
		wr(cpp_pkg::REG_PTB, 32'h0000_0008);
		pol(32'h0003_0000, 4'h0, P_WT);
		wr(cpp_pkg::REG_PTB, 32'h0);
		ext_cache_off <= 1'b1;
		pol(32'h0001_0234, 4'h0, P_UN);
		@(posedge clk);
		ext_cache_off <= 1'b0;
		ext_write_through <= 1'b1;
		pol(32'h0001_0234, 4'h0, P_WT);
		@(posedge clk);
		ext_write_through <= 1'b0;
		$display("test page and external done");
		u_core.push(32'h0000_1000);
		u_core.push(32'h0000_1004);
		u_core.store(32'h8000_1004, 32'h0000_0100);
		#1 chk("flush_alias", 32'h0, {31'h0, pq_flush_q});
		u_core.store(32'h0000_1004, 32'h0000_1010);
		#1 chk("flush_hit", 32'h1, {31'h0, pq_flush_q});
		chk("refetch", 32'h0000_1010, refetch_addr_q);
		u_core.push(32'h0000_1000);
		u_core.ser();
		#1 chk("flush_ser", 32'h1, {31'h0, pq_flush_q});
		for (i = 0; i < 8; i++) u_core.push(32'h100 + 4 * i);
		@(posedge clk);
		#1 chk("full", 32'h1, {31'h0, pq_full_q});
		rd(cpp_pkg::REG_STATUS, 32'h0000_08b0);
		u_core.pop();
		u_core.push(32'h0000_0200);
		u_core.store(32'h0000_0104, 32'h0000_0300);
		#1 chk("flush_full", 32'h1, {31'h0, pq_flush_q});
		chk("not_full", 32'h0, {31'h0, pq_full_q});
		rd(cpp_pkg::REG_FLUSHES, 32'h3);
		$display("test snoop done");
		stop_test();
	end
endmodule // cpp_top_tb
`default_nettype wire
